// ===== core/register_move_extend_unit.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "regmove_consts.svh"
module register_move_extend_unit #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN
);
  // below 6 bits the status word is out of reach
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W out of range");
  end

  // ==========================================================
  // bus registers
  logic [31:0] ctrl_ff, src_ff, dst_ff, a0l_ff, a0h_ff, a1l_ff, a1h_ff;
  logic [7:0]  a0x_ff, a1x_ff;
  logic [31:0] flags_ff, result_ff;
  logic        done_ff, wb_ff, rej_ff;
  logic        aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;

  // ==========================================================
  // write channel: address and data taken in either order
  wire aw_take  = S_AXI_AWVALID_IN && !aw_got_ff && !bvalid_ff;
  wire w_take   = S_AXI_WVALID_IN && !w_got_ff && !bvalid_ff;
  wire aw_have  = aw_got_ff || aw_take;
  wire w_have   = w_got_ff || w_take;
  wire do_write = aw_have && w_have && !bvalid_ff;
  wire [ADDR_W-1:0] wr_addr = aw_got_ff ? awaddr_ff : S_AXI_AWADDR_IN;
  wire [31:0]       wr_data = w_got_ff ? wdata_ff : S_AXI_WDATA_IN;
  wire [3:0]        wr_strb = w_got_ff ? wstrb_ff : S_AXI_WSTRB_IN;
  wire [7:0]        wa8     = 8'(wr_addr);
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire wr_ok = (wa8 <= `ADDR_FLAGS) && (wa8[1:0] == 2'h0);
  // writing the control word launches the operation
  wire launch = do_write && (wa8 == `ADDR_CTRL);

  assign S_AXI_AWREADY_OUT = !aw_got_ff && !bvalid_ff;
  assign S_AXI_WREADY_OUT  = !w_got_ff && !bvalid_ff;
  assign S_AXI_BVALID_OUT  = bvalid_ff;
  assign S_AXI_BRESP_OUT   = bresp_ff;

  // ==========================================================
  // operation decode from the new control word
  wire [31:0] nctl = (ctrl_ff & ~wmask) | (wr_data & wmask);
  wire [3:0]  op_raw = nctl[`CTRL_OP_LSB +: 4];
  wire [2:0]  opt    = nctl[`CTRL_OPT_LSB +: 3];
  wire        hi_sel = nctl[`CTRL_HALF_BIT];
  wire        dual   = nctl[`CTRL_DUAL_BIT];
  wire        par    = nctl[`CTRL_PAR_BIT];
  wire        len32  = nctl[`CTRL_LEN32_BIT];
  wire        same   = nctl[`CTRL_SAME_BIT];
  wire        acc1   = nctl[`CTRL_ACC_BIT];
  wire        cond   = flags_ff[`FLG_COND];
  wire        rnd_unb = flags_ff[`FLG_RND];

  wire is_cmov = (op_raw == 4'(regmove_pkg::OP_CMOV)) ||
                 (op_raw == 4'(regmove_pkg::OP_CMOV_NEG));
  wire is_hext = (op_raw == 4'(regmove_pkg::OP_ZEXT_H)) ||
                 (op_raw == 4'(regmove_pkg::OP_SEXT_H));
  wire is_accm = (op_raw >= 4'(regmove_pkg::OP_EXT_WR)) &&
                 (op_raw <= 4'(regmove_pkg::OP_ACC2HALF));
  wire bad_op  = (op_raw == 4'(regmove_pkg::OP_NONE)) ||
                 (op_raw > 4'(regmove_pkg::OP_ACC2HALF));
  wire reject  = bad_op ||
                 ((is_cmov || is_hext) && (par || len32)) ||
                 (is_accm && !len32) ||
                 (op_raw == 4'(regmove_pkg::OP_ACC2HALF) && dual && !same);

  // condition test; the negated form moves on a clear flag
  wire cond_ok = (op_raw == 4'(regmove_pkg::OP_CMOV)) ? cond
                                                      : !cond;

  // ==========================================================
  // accumulator extraction to one 16-bit half
  // acc value: 8-bit extension byte over the 32-bit word
  function automatic logic [16:0] extract(input logic [39:0] acc, input logic [2:0] o,
                                          input logic unb);
    logic signed [41:0] v;
    logic signed [41:0] r;
    logic [15:0] res;
    logic        sat;
    logic        rnd_on;
    logic [15:0] frac;
    v = 42'(signed'(acc));
    r = v;
    res = 16'h0000;
    sat = 1'b0;
    // round_select only matters for rounding options
    rnd_on = (o == 3'(regmove_pkg::OPT_DEFAULT)) || (o == 3'(regmove_pkg::OPT_FU)) ||
             (o == 3'(regmove_pkg::OPT_SCALED_ROUND_OPT)) || (o == 3'(regmove_pkg::OPT_IH));
    if (o == 3'(regmove_pkg::OPT_SCALED_ROUND_OPT) || o == 3'(regmove_pkg::OPT_SCALED_SIGNED_INT_OPT)) begin
      r = v <<< 1;
    end
    if (o == 3'(regmove_pkg::OPT_FU) || o == 3'(regmove_pkg::OPT_IU)) begin
      r = $signed({2'h0, acc});
    end
    if (rnd_on) begin
      frac = r[15:0];
      // unbiased: a tie rounds to even instead of up
      if (unb && frac == 16'h8000) begin
        r = r + (r[16] ? 42'sh8000 : 42'sh0);
      end else begin
        r = r + 42'sh8000;
      end
    end
    // saturate the already rounded value
    unique case (o)
      3'(regmove_pkg::OPT_IS), 3'(regmove_pkg::OPT_SCALED_SIGNED_INT_OPT): begin
        sat = (r > 42'sh7fff) || (r < -42'sh8000);
        res = (r > 42'sh7fff) ? 16'h7fff : (r < -42'sh8000) ? 16'h8000 : r[15:0];
      end
      3'(regmove_pkg::OPT_IU): begin
        sat = (r > 42'shffff);
        res = sat ? 16'hffff : r[15:0];
      end
      3'(regmove_pkg::OPT_T): begin
        res = r[31:16];
      end
      3'(regmove_pkg::OPT_FU): begin
        sat = (r > 42'sh0_ffff_ffff);
        res = sat ? 16'hffff : r[31:16];
      end
      default: begin
        sat = (r > 42'sh7fff_ffff) || (r < -42'sh8000_0000);
        res = (r > 42'sh7fff_ffff) ? 16'h7fff : (r < -42'sh8000_0000) ? 16'h8000 : r[31:16];
      end
    endcase
    return {sat, res};
  endfunction

  wire [39:0] acc0 = {a0x_ff, a0h_ff[15:0], a0l_ff[15:0]};
  wire [39:0] acc1v = {a1x_ff, a1h_ff[15:0], a1l_ff[15:0]};
  // the half bit picks high or low half; acc_zero feeds low, acc_one upper
  wire [16:0] ex0 = extract(acc0, opt, rnd_unb);
  wire [16:0] ex1 = extract(acc1v, opt, rnd_unb);

  // ==========================================================
  // result and flag computation
  logic [31:0] nxt_res;
  logic [31:0] nxt_flags;
  logic        nxt_wb;
  logic [7:0]  nxt_a0x, nxt_a1x;
  logic [15:0] nxt_a0l, nxt_a0h, nxt_a1l, nxt_a1h;
  logic        ovf;
  logic [15:0] wlo, whi;
  always_comb begin
    nxt_res   = dst_ff;
    nxt_flags = flags_ff;
    nxt_wb    = 1'b0;
    nxt_a0x = a0x_ff; nxt_a1x = a1x_ff;
    nxt_a0l = a0l_ff[15:0]; nxt_a0h = a0h_ff[15:0];
    nxt_a1l = a1l_ff[15:0]; nxt_a1h = a1h_ff[15:0];
    ovf = 1'b0;
    wlo = 16'h0000;
    whi = 16'h0000;
    unique case (op_raw)
      4'(regmove_pkg::OP_CMOV), 4'(regmove_pkg::OP_CMOV_NEG): begin
        // flags untouched; a failed condition keeps the old value
        nxt_res = cond_ok ? src_ff : dst_ff;
        nxt_wb  = cond_ok;
      end
      4'(regmove_pkg::OP_ZEXT_H): begin
        nxt_res = {16'h0000, src_ff[15:0]};
        nxt_wb  = 1'b1;
        nxt_flags[`FLG_ZERO]  = (src_ff[15:0] == 16'h0000);
        nxt_flags[`FLG_NEG]   = 1'b0;
        nxt_flags[`FLG_CARRY] = 1'b0;
        nxt_flags[`FLG_OVF]   = 1'b0;
      end
      4'(regmove_pkg::OP_SEXT_H): begin
        nxt_res = {{16{src_ff[15]}}, src_ff[15:0]};
        nxt_wb  = 1'b1;
        nxt_flags[`FLG_ZERO]  = (src_ff[15:0] == 16'h0000);
        nxt_flags[`FLG_NEG]   = src_ff[15];
        nxt_flags[`FLG_CARRY] = 1'b0;
        nxt_flags[`FLG_OVF]   = 1'b0;
      end
      4'(regmove_pkg::OP_EXT_WR): begin
        if (acc1) nxt_a1x = src_ff[7:0];
        else      nxt_a0x = src_ff[7:0];
      end
      4'(regmove_pkg::OP_EXT_RD): begin
        wlo = acc1 ? {{8{a1x_ff[7]}}, a1x_ff} : {{8{a0x_ff[7]}}, a0x_ff};
        nxt_res = {dst_ff[31:16], wlo};
        nxt_wb  = 1'b1;
      end
      4'(regmove_pkg::OP_ACC_LO): begin
        if (acc1) nxt_a1l = src_ff[15:0];
        else      nxt_a0l = src_ff[15:0];
      end
      4'(regmove_pkg::OP_ACC_HI): begin
        if (acc1) nxt_a1h = src_ff[31:16];
        else      nxt_a0h = src_ff[31:16];
      end
      4'(regmove_pkg::OP_ACC2HALF): begin
        // all eight 3-bit codes are default or one of seven modifiers
        wlo = ex0[15:0];
        whi = ex1[15:0];
        nxt_wb = 1'b1;
        if (dual) begin
          nxt_res = {whi, wlo};
          ovf = ex0[16] | ex1[16];
          nxt_flags[`FLG_ZERO] = (wlo == 16'h0000) | (whi == 16'h0000);
          nxt_flags[`FLG_NEG]  = wlo[15] | whi[15];
        end else if (hi_sel) begin
          nxt_res = {whi, dst_ff[15:0]};
          ovf = ex1[16];
          nxt_flags[`FLG_ZERO] = (whi == 16'h0000);
          nxt_flags[`FLG_NEG]  = whi[15];
        end else begin
          nxt_res = {dst_ff[31:16], wlo};
          ovf = ex0[16];
          nxt_flags[`FLG_ZERO] = (wlo == 16'h0000);
          nxt_flags[`FLG_NEG]  = wlo[15];
        end
        nxt_flags[`FLG_OVF] = ovf;
        if (ovf) nxt_flags[`FLG_OVF_STICKY] = 1'b1;
      end
      default: begin
        nxt_wb = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // register write and execute
  wire wsel_src  = do_write && wr_ok && (wa8 == `ADDR_SRC);
  wire wsel_dst  = do_write && wr_ok && (wa8 == `ADDR_DST_IN);
  wire wsel_a0l  = do_write && wr_ok && (wa8 == `ADDR_ACC0_LO);
  wire wsel_a0h  = do_write && wr_ok && (wa8 == `ADDR_ACC0_HI);
  wire wsel_a1l  = do_write && wr_ok && (wa8 == `ADDR_ACC1_LO);
  wire wsel_a1h  = do_write && wr_ok && (wa8 == `ADDR_ACC1_HI);
  wire wsel_flg  = do_write && wr_ok && (wa8 == `ADDR_FLAGS);
  wire exec      = launch && !reject;
  wire [31:0] wmerge_src = (src_ff & ~wmask) | (wr_data & wmask);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctrl_ff <= 32'h0; src_ff <= 32'h0; dst_ff <= 32'h0;
      a0l_ff <= 32'h0; a0h_ff <= 32'h0; a1l_ff <= 32'h0; a1h_ff <= 32'h0;
      a0x_ff <= 8'h0; a1x_ff <= 8'h0;
      flags_ff <= `FLAGS_RESET; result_ff <= 32'h0;
      done_ff <= 1'b0; wb_ff <= 1'b0; rej_ff <= 1'b0;
    end else begin
      if (launch) ctrl_ff <= nctl;
      if (wsel_src) src_ff <= wmerge_src;
      if (wsel_dst) dst_ff <= (dst_ff & ~wmask) | (wr_data & wmask);
      if (wsel_flg) flags_ff <= (flags_ff & ~wmask) | (wr_data & wmask);
      if (wsel_a0l) a0l_ff <= (a0l_ff & ~wmask) | (wr_data & wmask);
      if (wsel_a0h) a0h_ff <= (a0h_ff & ~wmask) | (wr_data & wmask);
      if (wsel_a1l) a1l_ff <= (a1l_ff & ~wmask) | (wr_data & wmask);
      if (wsel_a1h) a1h_ff <= (a1h_ff & ~wmask) | (wr_data & wmask);
      if (launch) begin
        done_ff <= 1'b1;
        rej_ff  <= reject;
        wb_ff   <= exec && nxt_wb;
      end
      if (exec) begin
        flags_ff <= nxt_flags;
        a0x_ff <= nxt_a0x; a1x_ff <= nxt_a1x;
        a0l_ff <= {16'h0, nxt_a0l}; a0h_ff <= {16'h0, nxt_a0h};
        a1l_ff <= {16'h0, nxt_a1l}; a1h_ff <= {16'h0, nxt_a1h};
        if (nxt_wb) begin
          result_ff <= nxt_res;
          dst_ff    <= nxt_res;
        end
      end
    end
  end

  // ==========================================================
  // axi handshake state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      aw_got_ff <= 1'b0; w_got_ff <= 1'b0; bvalid_ff <= 1'b0;
      awaddr_ff <= '0; wdata_ff <= 32'h0; wstrb_ff <= 4'h0; bresp_ff <= 2'h0;
    end else begin
      if (aw_take) awaddr_ff <= S_AXI_AWADDR_IN;
      if (w_take) begin
        wdata_ff <= S_AXI_WDATA_IN;
        wstrb_ff <= S_AXI_WSTRB_IN;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (aw_take) aw_got_ff <= 1'b1;
        if (w_take)  w_got_ff  <= 1'b1;
        if (bvalid_ff && S_AXI_BREADY_IN) bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  wire [7:0] ra8 = 8'(S_AXI_ARADDR_IN);
  wire [31:0] status_w = {29'h0, rej_ff, wb_ff, done_ff};
  wire rd_ok = (ra8 <= `ADDR_STATUS) && (ra8[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (ra8 == `ADDR_CTRL)    ? ctrl_ff :
    (ra8 == `ADDR_SRC)     ? src_ff :
    (ra8 == `ADDR_DST_IN)  ? dst_ff :
    (ra8 == `ADDR_ACC0_LO) ? a0l_ff :
    (ra8 == `ADDR_ACC0_HI) ? {24'h0, a0x_ff} | {a0h_ff[15:0], 16'h0} :
    (ra8 == `ADDR_ACC1_LO) ? a1l_ff :
    (ra8 == `ADDR_ACC1_HI) ? {24'h0, a1x_ff} | {a1h_ff[15:0], 16'h0} :
    (ra8 == `ADDR_FLAGS)   ? flags_ff :
    (ra8 == `ADDR_RESULT)  ? result_ff :
    (ra8 == `ADDR_STATUS)  ? status_w : 32'h0;
  wire ar_take = S_AXI_ARVALID_IN && !rvalid_ff;
  assign S_AXI_ARREADY_OUT = !rvalid_ff;
  assign S_AXI_RVALID_OUT  = rvalid_ff;
  assign S_AXI_RDATA_OUT   = rdata_ff;
  assign S_AXI_RRESP_OUT   = rresp_ff;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rvalid_ff <= 1'b0; rdata_ff <= 32'h0; rresp_ff <= 2'h0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_ok ? rd_mux : 32'h0;
      rresp_ff  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_ff && S_AXI_RREADY_IN) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : register_move_extend_unit
`default_nettype wire

// ===== core/regmove_consts.svh
`ifndef REGMOVE_CONSTS_SVH
`define REGMOVE_CONSTS_SVH
// ==========================================================
// register map (byte addresses, aligned words)
`define ADDR_CTRL      8'h00
`define ADDR_SRC       8'h04
`define ADDR_DST_IN    8'h08
`define ADDR_ACC0_LO   8'h0c
`define ADDR_ACC0_HI   8'h10
`define ADDR_ACC1_LO   8'h14
`define ADDR_ACC1_HI   8'h18
`define ADDR_FLAGS     8'h1c
`define ADDR_RESULT    8'h20
`define ADDR_STATUS    8'h24
// ==========================================================
// control word fields
`define CTRL_OP_LSB    0
`define CTRL_OPT_LSB   4
`define CTRL_HALF_BIT  8
`define CTRL_DUAL_BIT  9
`define CTRL_PAR_BIT   10
`define CTRL_LEN32_BIT 11
`define CTRL_SAME_BIT  12
`define CTRL_ACC_BIT   13
// ==========================================================
// flag register bit positions
`define FLG_ZERO       0
`define FLG_NEG        1
`define FLG_COND       5
`define FLG_RND        8
`define FLG_CARRY      12
`define FLG_OVF        24
`define FLG_OVF_STICKY 25
`define FLAGS_RESET    32'h0000_0000
// ==========================================================
// axi responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ===== core/regmove_pkg.sv
`default_nettype none
package regmove_pkg;
  // ==========================================================
  // operations
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_CMOV     = 4'h1,
    OP_CMOV_NEG = 4'h2,
    OP_ZEXT_H   = 4'h3,
    OP_SEXT_H   = 4'h4,
    OP_EXT_WR   = 4'h5,
    OP_EXT_RD   = 4'h6,
    OP_ACC_LO   = 4'h7,
    OP_ACC_HI   = 4'h8,
    OP_ACC2HALF = 4'h9
  } op_t;
  // ==========================================================
  // extraction options
  typedef enum logic [2:0] {
    OPT_DEFAULT = 3'h0,
    OPT_FU      = 3'h1,
    OPT_IS      = 3'h2,
    OPT_IU      = 3'h3,
    OPT_T       = 3'h4,
    OPT_SCALED_ROUND_OPT   = 3'h5,
    OPT_SCALED_SIGNED_INT_OPT    = 3'h6,
    OPT_IH      = 3'h7
  } opt_t;
endpackage : regmove_pkg
`default_nettype wire

// ===== testbench/regmove_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus handshake checker
module regmove_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              CLK_IN,
  input wire logic              RST_IN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic              S_AXI_AWVALID_IN,
  input wire logic              S_AXI_AWREADY_OUT,
  input wire logic              S_AXI_WVALID_IN,
  input wire logic              S_AXI_WREADY_OUT,
  input wire logic [1:0]        S_AXI_BRESP_OUT,
  input wire logic              S_AXI_BVALID_OUT,
  input wire logic              S_AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic              S_AXI_ARVALID_IN,
  input wire logic              S_AXI_ARREADY_OUT,
  input wire logic [31:0]       S_AXI_RDATA_OUT,
  input wire logic [1:0]        S_AXI_RRESP_OUT,
  input wire logic              S_AXI_RVALID_OUT,
  input wire logic              S_AXI_RREADY_IN
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence s_ar;
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  endsequence
  sequence s_wr;
    S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  endsequence
  property p_r_ans;
    s_ar |=> S_AXI_RVALID_OUT;
  endproperty
  property p_r_bad;
    s_ar ##0 (S_AXI_ARADDR_IN > 8'h24) |=> S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0;
  endproperty
  property p_r_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  property p_r_drop;
    S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT;
  endproperty
  property p_ar_rdy;
    S_AXI_ARREADY_OUT == !S_AXI_RVALID_OUT;
  endproperty
  property p_b_ans;
    s_wr |=> S_AXI_BVALID_OUT;
  endproperty
  // read-only and unmapped places refuse writes
  property p_b_ro;
    s_wr ##0 (S_AXI_AWADDR_IN >= 8'h20) |=> S_AXI_BRESP_OUT == 2'h2;
  endproperty
  property p_b_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT);
  endproperty
  property p_b_block;
    S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT;
  endproperty
  a_r_ans:   assert property (p_r_ans)   else $error("no read answer");
  a_r_bad:   assert property (p_r_bad)   else $error("bad read not refused");
  a_r_hold:  assert property (p_r_hold)  else $error("read answer not held");
  a_r_drop:  assert property (p_r_drop)  else $error("read answer not dropped");
  a_ar_rdy:  assert property (p_ar_rdy)  else $error("arready wrong");
  a_b_ans:   assert property (p_b_ans)   else $error("no write answer");
  a_b_ro:    assert property (p_b_ro)    else $error("bad write not refused");
  a_b_hold:  assert property (p_b_hold)  else $error("write answer not held");
  a_b_block: assert property (p_b_block) else $error("write taken while answer pending");
endmodule : regmove_asserts
bind register_move_extend_unit regmove_asserts #(.ADDR_W(ADDR_W)) i_regmove_asserts (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .S_AXI_AWADDR_IN(S_AXI_AWADDR_IN),
  .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
  .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
  .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
  .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RRESP_OUT(S_AXI_RRESP_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN));
`default_nettype wire

// ===== testbench/register_move_extend_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "regmove_consts.svh"
module register_move_extend_unit_tb_top;
  // ==========================================================
  // signals
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             awvalid = 1'b0;
  logic             wvalid = 1'b0;
  logic             bready = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready = 1'b0;
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int               miscompares = 0;
  int               n_tests = 0;
  int               cyc = 0;
  logic [31:0]      seed = 32'h2c0e152f;
  typedef struct { string nm; logic [33:0] ex; logic [31:0] mk; } note_t;
  note_t            rq[$];
  note_t            bq[$];
  localparam logic [5:0] HALF = 6'h01, DUAL = 6'h02, PAR = 6'h04;
  localparam logic [5:0] L32 = 6'h08, SAME = 6'h10, ACC1 = 6'h20;
  always #4 clk = ~clk;
  register_move_extend_unit i_register_move_extend_unit (
    .CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cw(regmove_pkg::op_t o, regmove_pkg::opt_t t, logic [5:0] b);
    return {18'h0, b, 1'b0, t, o};
  endfunction : cw
  task automatic check(string nm, logic [33:0] seen, logic [33:0] ex);
    n_tests++;
    if (seen !== ex) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // bus master; bready and rready start low at random to stall the answer
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bq.push_back('{"bresp", {(a[1:0] != 0 || a > 8'h1c) ? 2'h2 : 2'h0, 32'h0}, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= seed[3];
    forever begin
      @(posedge clk);
      if (bvalid && bready) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, string nm);
    rq.push_back('{nm, {(a[1:0] != 0 || a > 8'h24) ? 2'h2 : 2'h0, e & m}, m});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= seed[5];
    forever begin
      @(posedge clk);
      if (rvalid && rready) break;
      if (arready) arvalid <= 1'b0;
      rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask : rd
  task automatic op(logic [31:0] c);
    wr(`ADDR_CTRL, c);
  endtask : op
  task automatic set_acc(logic [5:0] sel, logic [31:0] v);
    wr(`ADDR_SRC, v);
    op(cw(regmove_pkg::OP_ACC_LO, regmove_pkg::OPT_DEFAULT, L32 | sel));
    op(cw(regmove_pkg::OP_ACC_HI, regmove_pkg::OPT_DEFAULT, L32 | sel));
  endtask : set_acc
  // ==========================================================
  // result watcher: oldest note against each answer
  always @(posedge clk) begin
    note_t n;
    if (rvalid && rready && rq.size() > 0) begin
      n = rq.pop_front();
      check(n.nm, {rresp, rdata & n.mk}, n.ex);
    end
    if (bvalid && bready && bq.size() > 0) begin
      n = bq.pop_front();
      check(n.nm, {bresp, 32'h0}, n.ex);
    end
  end
  // a run of several hundred cycles is expected; the ceiling leaves ample room
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] r, d, f, x;
    logic [31:0] bad [6];
    int          i;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_FLAGS, `FLAGS_RESET, 32'hffffffff, "flags reset");
    rd(8'h28, 32'h0, 32'hffffffff, "unmapped");
    rd(8'h06, 32'h0, 32'hffffffff, "unaligned");
    wr(`ADDR_RESULT, 32'h1);
    for (i = 0; i < 4; i++) begin
      r = rnd();
      d = rnd();
      f = 32'h0300_1103 | {26'h0, i[0], 5'h0};
      wr(`ADDR_FLAGS, f);
      wr(`ADDR_SRC, r);
      wr(`ADDR_DST_IN, d);
      op(cw(i[1] ? regmove_pkg::OP_CMOV_NEG : regmove_pkg::OP_CMOV, regmove_pkg::OPT_DEFAULT, 0));
      x = (i[1] ^ i[0]) ? r : d;
      rd(`ADDR_DST_IN, x, 32'hffffffff, "cmov dst");
      rd(`ADDR_STATUS, {30'h0, i[1] ^ i[0], 1'b1}, 32'h7, "cmov status");
      rd(`ADDR_FLAGS, f, 32'hffffffff, "cmov flags");
    end
    bad = '{cw(regmove_pkg::OP_CMOV, regmove_pkg::OPT_DEFAULT, PAR),
            cw(regmove_pkg::OP_ZEXT_H, regmove_pkg::OPT_DEFAULT, L32),
            cw(regmove_pkg::OP_SEXT_H, regmove_pkg::OPT_DEFAULT, PAR),
            cw(regmove_pkg::OP_ACC_LO, regmove_pkg::OPT_DEFAULT, 0),
            cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32 | DUAL),
            cw(regmove_pkg::OP_NONE, regmove_pkg::OPT_DEFAULT, 0)};
    for (i = 0; i < 6; i++) begin
      op(bad[i]);
      rd(`ADDR_STATUS, 32'h4, 32'h6, "refused");
    end
    rd(`ADDR_DST_IN, x, 32'hffffffff, "refused dst");
    for (i = 0; i < 6; i++) begin
      r = (i < 2) ? 32'hffff_0000 : (i < 4) ? (rnd() | 32'h8000) : (rnd() & 32'hffff_7fff);
      wr(`ADDR_FLAGS, 32'h0300_1123);
      wr(`ADDR_SRC, r);
      op(cw(i[0] ? regmove_pkg::OP_SEXT_H : regmove_pkg::OP_ZEXT_H,
            regmove_pkg::OPT_DEFAULT, 0));
      x = i[0] ? {{16{r[15]}}, r[15:0]} : {16'h0, r[15:0]};
      rd(`ADDR_DST_IN, x, 32'hffffffff, "extend dst");
      f = 32'h0200_0120 | {30'h0, x[31], x == 32'h0};
      rd(`ADDR_FLAGS, f, 32'hffffffff, "extend flags");
    end
    r = rnd();
    d = rnd();
    wr(`ADDR_SRC, r);
    op(cw(regmove_pkg::OP_ACC_LO, regmove_pkg::OPT_DEFAULT, L32));
    op(cw(regmove_pkg::OP_ACC_HI, regmove_pkg::OPT_DEFAULT, L32 | ACC1));
    rd(`ADDR_ACC0_LO, {16'h0, r[15:0]}, 32'hffff, "acc low");
    rd(`ADDR_ACC1_HI, {r[31:16], 16'h0}, 32'hffff0000, "acc high");
    op(cw(regmove_pkg::OP_EXT_WR, regmove_pkg::OPT_DEFAULT, L32 | ACC1));
    rd(`ADDR_ACC1_HI, {24'h0, r[7:0]}, 32'hff, "ext byte");
    wr(`ADDR_DST_IN, d);
    op(cw(regmove_pkg::OP_EXT_RD, regmove_pkg::OPT_DEFAULT, L32 | ACC1));
    rd(`ADDR_DST_IN, {d[31:16], {8{r[7]}}, r[7:0]}, 32'hffffffff, "ext read");
    wr(`ADDR_SRC, 32'h0);
    op(cw(regmove_pkg::OP_EXT_WR, regmove_pkg::OPT_DEFAULT, L32 | ACC1));
    // positive halves keep the extraction clear of saturation
    r = rnd() & 32'h7fff_7fff;
    set_acc(0, {r[15:0], 16'h0});
    set_acc(ACC1, {r[31:16], 16'h0});
    op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32 | DUAL | SAME));
    rd(`ADDR_DST_IN, r, 32'hffffffff, "dual default");
    set_acc(0, {16'h0, r[31:16]});
    set_acc(ACC1, {16'h0, r[15:0]});
    op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_IS, L32 | DUAL | SAME));
    rd(`ADDR_DST_IN, {r[15:0], r[31:16]}, 32'hffffffff, "dual integer");
    op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32 | HALF | ACC1));
    rd(`ADDR_DST_IN, {16'h0, r[31:16]}, 32'hffffffff, "single high");
    for (i = 1; i < 8; i++) begin
      op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::opt_t'(i[2:0]), L32));
      rd(`ADDR_STATUS, 32'h0, 32'h4, "option taken");
    end
    set_acc(0, 32'h0002_8000);
    for (i = 0; i < 2; i++) begin
      wr(`ADDR_FLAGS, {23'h0, i[0], 8'h0});
      op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32));
      rd(`ADDR_DST_IN, i[0] ? 32'h2 : 32'h3, 32'hffff, "round select");
      op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_T, L32));
      rd(`ADDR_DST_IN, 32'h2, 32'hffff, "truncate");
    end
    set_acc(0, 32'h7fff_8000);
    wr(`ADDR_FLAGS, 32'h0);
    op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32));
    rd(`ADDR_DST_IN, 32'h7fff, 32'hffff, "round then saturate");
    rd(`ADDR_FLAGS, 32'h0300_0000, 32'h0300_0000, "overflow set");
    set_acc(0, 32'h0001_0000);
    op(cw(regmove_pkg::OP_ACC2HALF, regmove_pkg::OPT_DEFAULT, L32));
    rd(`ADDR_FLAGS, 32'h0200_0000, 32'h0300_0000, "overflow clear");
    @(posedge clk);
    give_verdict();
  end
endmodule : register_move_extend_unit_tb_top
`default_nettype wire
